// ---- sgtt_pkg.sv ----
/*
 Package for the stop-grant and thermal-trip controller: states and constants.
 Assumes a single 25 MHz bus clock domain.
*/
package sgtt_pkg;
  typedef enum logic [1:0] {
    SGTT_RUN,
    SGTT_STOPGRANT,
    SGTT_SLEEP,
    SGTT_RESUME
  } sgtt_state_e;

  localparam int unsigned SYNC_STAGES = 2;
  localparam int unsigned CLK_PERIOD_NS = 40;
  // Junction trip level in degrees C, sensed by the analog sensor outside
  localparam int unsigned TRIP_LEVEL_C = 135;
  // Units behind the clock gates: bus, interrupt controller, then core units
  localparam int unsigned UNIT_BUS = 0;
  localparam int unsigned UNIT_INTC = 1;
  localparam int unsigned NUM_UNITS_DEF = 4;
  localparam int unsigned IRQ_WIDTH_DEF = 4;
  localparam logic [0:0] ACK_PULSE = 1'h1;
endpackage

// ---- sgtt_sync.sv ----
/*
 Two-flop synchroniser for asynchronous level inputs, one per bit.
 Assumes inputs come from outside the i_clk domain.
*/
module sgtt_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [0:0] RESET_VAL = 1'h1
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  if (WIDTH < 1) begin
    $error("sgtt_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      meta_q <= {WIDTH{RESET_VAL}};
      sync_q <= {WIDTH{RESET_VAL}};
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule

// ---- sgtt_ctrl.sv ----
/*
 Stop-grant / sleep sequencer and latched thermal-trip output.
 Assumes the clock-stop, sleep and trip-sensor inputs are asynchronous pins,
 the bus interface issues the acknowledge transaction on o_sg_ack_req, and
 i_rstn is the system reset, synchronous to the bus clock.
*/
// Functional notes
// - Clock-stop request asserted: enter stop-grant and request the acknowledge transaction.
// - In stop-grant only bus and interrupt-controller unit clocks keep running.
// - In stop-grant snooping stays enabled and interrupts are latched pending.
// - On release: restart all clocks, service latched interrupts, then resume execution.
// - Clock-stop is asynchronous and never touches the external bus clock.
// - Sensor trip above about 135 C halts execution and asserts trip output low.
// - Trip output and halt stay latched until system reset becomes active.
// - Reset clears trip only when sensor no longer trips; otherwise it persists.
// - Sleep request in stop-grant enters sleep: all unit clocks off, no snoops.
// - Sleep release returns to stop-grant and restarts bus and interrupt clocks.
module sgtt_ctrl #(
  parameter int unsigned NUM_UNITS = sgtt_pkg::NUM_UNITS_DEF,
  parameter int unsigned IRQ_WIDTH = sgtt_pkg::IRQ_WIDTH_DEF
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_clock_stop_request_n,
  input wire logic i_sleep_request_n,
  input wire logic i_trip_sensor,
  input wire logic [IRQ_WIDTH-1:0] i_irq,
  input wire logic i_irq_taken,
  output logic o_thermal_shutdown_n,
  output logic o_sg_ack_req,
  output logic [NUM_UNITS-1:0] o_unit_clk_en,
  output logic o_snoop_en,
  output logic o_exec_en,
  output logic [IRQ_WIDTH-1:0] o_irq_pending
);
  // Refuse sizes that the unit mask and the interrupt logic cannot serve
  if (NUM_UNITS < 3) begin
    $error("sgtt_ctrl: NUM_UNITS must cover bus, intc and one core unit");
  end
  if (IRQ_WIDTH < 1) begin
    $error("sgtt_ctrl: IRQ_WIDTH must be at least 1");
  end

  logic stop_n_s;
  logic sleep_n_s;
  logic trip_s;
  logic [1:0] req_s;
  sgtt_pkg::sgtt_state_e state_q;
  sgtt_pkg::sgtt_state_e state_d;
  logic trip_q;
  logic ack_q;
  logic [IRQ_WIDTH-1:0] pend_q;
  logic [NUM_UNITS-1:0] clk_en_q;
  logic snoop_q;
  logic exec_q;

  // Pins into the bus clock domain; the bus clock itself is never gated here
  sgtt_sync #(.WIDTH(2), .RESET_VAL(1'h1)) u_sync_req (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_async({i_clock_stop_request_n, i_sleep_request_n}),
    .o_sync(req_s)
  );

  assign stop_n_s = req_s[1];
  assign sleep_n_s = req_s[0];

  // Sensor sync keeps sampling through reset so the latch sees the live sensor
  sgtt_sync #(.WIDTH(1), .RESET_VAL(1'h0)) u_sync_trip (
    .i_clk(i_clk),
    .i_rstn(1'h1),
    .i_async(i_trip_sensor),
    .o_sync(trip_s)
  );

  function automatic logic [NUM_UNITS-1:0] unit_mask(input sgtt_pkg::sgtt_state_e st,
                                                     input logic halted);
    logic [NUM_UNITS-1:0] m;
    m = '0;
    case (st)
      sgtt_pkg::SGTT_RUN, sgtt_pkg::SGTT_RESUME: m = halted ? '0 : '1;
      sgtt_pkg::SGTT_STOPGRANT: begin
        m[sgtt_pkg::UNIT_BUS] = 1'h1;
        m[sgtt_pkg::UNIT_INTC] = 1'h1;
      end
      sgtt_pkg::SGTT_SLEEP: m = '0;
      default: m = '0;
    endcase
    return m;
  endfunction

  // Sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      sgtt_pkg::SGTT_RUN: begin
        if (!stop_n_s) state_d = sgtt_pkg::SGTT_STOPGRANT;
      end
      sgtt_pkg::SGTT_STOPGRANT: begin
        if (!sleep_n_s) state_d = sgtt_pkg::SGTT_SLEEP;
        else if (stop_n_s) state_d = sgtt_pkg::SGTT_RESUME;
      end
      sgtt_pkg::SGTT_SLEEP: begin
        if (sleep_n_s) state_d = sgtt_pkg::SGTT_STOPGRANT;
      end
      sgtt_pkg::SGTT_RESUME: begin
        if (!stop_n_s) state_d = sgtt_pkg::SGTT_STOPGRANT;
        else if (pend_q == '0) state_d = sgtt_pkg::SGTT_RUN;
      end
      default: state_d = sgtt_pkg::SGTT_RUN;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) state_q <= sgtt_pkg::SGTT_RUN;
    else state_q <= state_d;
  end

  // One-cycle request for the acknowledge transaction on stop-grant entry from run or resume
  always_ff @(posedge i_clk) begin
    if (!i_rstn) ack_q <= 1'h0;
    else ack_q <= (state_q == sgtt_pkg::SGTT_RUN || state_q == sgtt_pkg::SGTT_RESUME) &&
                  state_d == sgtt_pkg::SGTT_STOPGRANT;
  end

  // Thermal latch: sets on trip, clears only while reset sees a cool sensor
  always_ff @(posedge i_clk) begin
    if (!i_rstn) trip_q <= trip_s;
    else if (trip_s) trip_q <= 1'h1;
  end

  // Pending interrupts: latched outside sleep, set wins over service
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      pend_q <= '0;
    end else begin
      for (int i = 0; i < IRQ_WIDTH; i++) begin
        if (state_q != sgtt_pkg::SGTT_SLEEP && i_irq[i]) pend_q[i] <= 1'h1;
        else if (i_irq_taken && state_q != sgtt_pkg::SGTT_STOPGRANT &&
                 state_q != sgtt_pkg::SGTT_SLEEP && !trip_q &&
                 pend_q[i] && ((pend_q & ((IRQ_WIDTH'(1) << i) - 1'b1)) == '0))
          pend_q[i] <= 1'h0;
      end
    end
  end

  // Clock gates, snoop enable and execution enable
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      clk_en_q <= '1;
      snoop_q <= 1'h1;
      exec_q <= 1'h0;
    end else begin
      clk_en_q <= unit_mask(state_d, trip_q | trip_s);
      snoop_q <= state_d != sgtt_pkg::SGTT_SLEEP;
      exec_q <= state_d == sgtt_pkg::SGTT_RUN && !(trip_q | trip_s);
    end
  end

  assign o_thermal_shutdown_n = ~trip_q;
  assign o_sg_ack_req = ack_q;
  assign o_unit_clk_en = clk_en_q;
  assign o_snoop_en = snoop_q;
  assign o_exec_en = exec_q;
  assign o_irq_pending = pend_q;

  // Checks
  AST_ACK_ON_ENTRY: assert property (@(posedge i_clk) disable iff (!i_rstn)
    $rose(state_q == sgtt_pkg::SGTT_STOPGRANT) && $past(state_q) != sgtt_pkg::SGTT_SLEEP
    |-> o_sg_ack_req)
    else $error("no acknowledge on stop-grant entry");
  AST_SG_GATES: assert property (@(posedge i_clk) disable iff (!i_rstn)
    state_q == sgtt_pkg::SGTT_STOPGRANT && $stable(state_q) |->
    o_unit_clk_en[sgtt_pkg::UNIT_BUS] && o_unit_clk_en[sgtt_pkg::UNIT_INTC] &&
    o_unit_clk_en[NUM_UNITS-1] == 1'h0 && !o_exec_en)
    else $error("wrong unit clocks in stop-grant");
  AST_SG_LATCH_IRQ: assert property (@(posedge i_clk) disable iff (!i_rstn)
    state_q == sgtt_pkg::SGTT_STOPGRANT && i_irq[0] |=> o_irq_pending[0])
    else $error("interrupt lost in stop-grant");
  AST_RESUME_ORDER: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_exec_en |-> o_irq_pending == '0 || $past(o_exec_en))
    else $error("execution resumed with interrupts pending");
  AST_TRIP_HALT: assert property (@(posedge i_clk) disable iff (!i_rstn)
    trip_s |=> !o_exec_en ##1 !o_thermal_shutdown_n)
    else $error("trip did not halt and signal");
  AST_TRIP_HOLD: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !o_thermal_shutdown_n |=> !o_thermal_shutdown_n && !o_exec_en)
    else $error("trip output released without reset");
  AST_RESET_CLEAR: assert property (@(posedge i_clk)
    !i_rstn && !trip_s |=> o_thermal_shutdown_n)
    else $error("reset with cool sensor left trip set");
  AST_RESET_HOT: assert property (@(posedge i_clk)
    !i_rstn && trip_s |=> !o_thermal_shutdown_n)
    else $error("reset with hot sensor released trip output");
  AST_SLEEP_OFF: assert property (@(posedge i_clk) disable iff (!i_rstn)
    state_q == sgtt_pkg::SGTT_SLEEP && $stable(state_q) |-> o_unit_clk_en == '0 && !o_snoop_en)
    else $error("clocks or snoop running in sleep");
  AST_SLEEP_EXIT: assert property (@(posedge i_clk) disable iff (!i_rstn)
    state_q == sgtt_pkg::SGTT_SLEEP && sleep_n_s |=> state_q == sgtt_pkg::SGTT_STOPGRANT)
    else $error("sleep not left on release");
  AST_SYNC_LAT: assert property (@(posedge i_clk) disable iff (!i_rstn)
    state_q == sgtt_pkg::SGTT_RUN && $past(i_clock_stop_request_n)
    |=> state_q == sgtt_pkg::SGTT_RUN)
    else $error("clock-stop used before synchronisation");

  // Acknowledge width, snoop in stop-grant, interrupts frozen in sleep
  AST_ACK_ONE: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_sg_ack_req |=> !o_sg_ack_req)
    else $error("acknowledge request longer than one cycle");
  AST_SNOOP_SG: assert property (@(posedge i_clk) disable iff (!i_rstn)
    state_q == sgtt_pkg::SGTT_STOPGRANT |-> o_snoop_en)
    else $error("snooping off in stop-grant");
  AST_SLEEP_HOLD: assert property (@(posedge i_clk) disable iff (!i_rstn)
    state_q == sgtt_pkg::SGTT_SLEEP |=> $stable(o_irq_pending))
    else $error("pending interrupts changed in sleep");

  COV_STOPGRANT: cover property (@(posedge i_clk) disable iff (!i_rstn)
    state_q == sgtt_pkg::SGTT_STOPGRANT ##[1:50] state_q == sgtt_pkg::SGTT_RUN);
  COV_SLEEP: cover property (@(posedge i_clk) disable iff (!i_rstn)
    state_q == sgtt_pkg::SGTT_SLEEP ##[1:50] state_q == sgtt_pkg::SGTT_STOPGRANT);
  COV_REENTRY: cover property (@(posedge i_clk) disable iff (!i_rstn)
    state_q == sgtt_pkg::SGTT_RESUME ##1 state_q == sgtt_pkg::SGTT_STOPGRANT);
  COV_TRIP: cover property (@(posedge i_clk) $fell(o_thermal_shutdown_n));
  COV_TRIP_CLEAR: cover property (@(posedge i_clk) $rose(o_thermal_shutdown_n));
endmodule

// ---- sgtt_sys_model.sv ----
/*
 System core logic model driving the clock-stop and sleep request pins.
 Assumes the bench gives its wishes as levels, sampled on the bus clock.
*/
module sgtt_sys_model (
  input wire logic i_clk,
  input wire logic i_want_stop,
  input wire logic i_want_sleep,
  output logic o_clock_stop_request_n,
  output logic o_sleep_request_n
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_clock_stop_request_n = 1'b1;
    o_sleep_request_n = 1'b1;
  end
  // Sleep only inside a stop request, and stop held until sleep is released
  always @(posedge i_clk) begin
    o_clock_stop_request_n <= #1 !(i_want_stop || !o_sleep_request_n);
    o_sleep_request_n <= #1 !(i_want_sleep && i_want_stop && !o_clock_stop_request_n);
  end
endmodule

// ---- test_stop_grant_thermal_trip_ctrl.sv ----
/*
 Self-checking bench for the stop-grant and thermal-trip controller.
 Assumes the design is sgtt_ctrl with default widths and the system model beside it.
*/
module test_stop_grant_thermal_trip_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic want_stop = 1'b0;
  logic want_sleep = 1'b0;
  logic i_trip_sensor = 1'b0;
  logic [3:0] i_irq = 4'h0;
  logic i_irq_taken = 1'b0;
  logic stop_n, sleep_n, shut_n, ack, snoop, exec;
  logic [3:0] clk_en, pending, exp_pend;
  int mismatches = 0;
  int tests_run = 0;
  int acks = 0;
  always #20 i_clk = ~i_clk;

  sgtt_sys_model sgtt_sys_model_i (.i_clk(i_clk), .i_want_stop(want_stop),
    .i_want_sleep(want_sleep), .o_clock_stop_request_n(stop_n), .o_sleep_request_n(sleep_n));
  sgtt_ctrl sgtt_ctrl_i (.i_clk(i_clk), .i_rstn(i_rstn), .i_clock_stop_request_n(stop_n),
    .i_sleep_request_n(sleep_n), .i_trip_sensor(i_trip_sensor), .i_irq(i_irq),
    .i_irq_taken(i_irq_taken), .o_thermal_shutdown_n(shut_n), .o_sg_ack_req(ack),
    .o_unit_clk_en(clk_en), .o_snoop_en(snoop), .o_exec_en(exec), .o_irq_pending(pending));

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic check(input string what, input logic [3:0] exp, input logic [3:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  function automatic logic [3:0] drop_lowest(input logic [3:0] v);
    return v & (v - 4'h1);
  endfunction
  task automatic reset_dut(input logic hot);
    i_trip_sensor = hot;
    i_rstn = 1'b0;
    tick(6);
    i_rstn = 1'b1;
    tick(3);
  endtask
  task automatic pulse_irq(input logic [3:0] v);
    i_irq = v;
    tick(1);
    i_irq = 4'h0;
    tick(1);
  endtask
  task automatic release_and_serve;
    want_stop = 1'b0;
    tick(7);
    check("clk_en on release", 4'hf, clk_en);
    check("exec while pending", 4'h0, {3'h0, exec});
    i_irq_taken = 1'b1;
    while (exp_pend != 4'h0) begin
      tick(1);
      exp_pend = drop_lowest(exp_pend);
      check("pending serviced", exp_pend, pending);
    end
    i_irq_taken = 1'b0;
    tick(3);
    check("exec resumed", 4'h1, {3'h0, exec});
  endtask

  task automatic sg_cycle(input logic [3:0] r);
    int k;
    logic seen;
    k = 0;
    seen = 1'b0;
    want_stop = 1'b1;
    while (ack !== 1'b1 && k < 10) begin
      tick(1);
      k++;
    end
    check("ack", 4'h1, {3'h0, ack});
    check("clk_en in stop-grant", 4'h3, clk_en);
    check("exec in stop-grant", 4'h0, {3'h0, exec});
    tick(1);
    check("ack width", 4'h0, {3'h0, ack});
    check("snoop in stop-grant", 4'h1, {3'h0, snoop});
    pulse_irq(r);
    exp_pend = r;
    check("pending in stop-grant", exp_pend, pending);
    want_sleep = 1'b1;
    tick(6);
    check("clk_en in sleep", 4'h0, clk_en);
    check("snoop in sleep", 4'h0, {3'h0, snoop});
    pulse_irq(4'hf);
    check("pending in sleep", exp_pend, pending);
    want_sleep = 1'b0;
    repeat (6) begin
      tick(1);
      if (ack === 1'b1) seen = 1'b1;
    end
    check("ack after sleep", 4'h0, {3'h0, seen});
    check("clk_en after sleep", 4'h3, clk_en);
    check("snoop after sleep", 4'h1, {3'h0, snoop});
    release_and_serve();
    $display("stop-grant cycle with %h done", r);
  endtask

  initial begin
    #100000;
    mismatches++;
    $display("watchdog expired");
    tally_and_finish();
  end

  initial begin
    void'($urandom(96387));
    tick(6);
    i_rstn = 1'b1;
    tick(3);
    check("trip after reset", 4'h1, {3'h0, shut_n});
    check("exec after reset", 4'h1, {3'h0, exec});
    check("clk_en after reset", 4'hf, clk_en);
    $display("reset test done");
    sg_cycle(4'h1);
    sg_cycle(4'hf);
    repeat (4) sg_cycle(4'($urandom_range(15, 1)));
    // Clock-stop returns while interrupts still wait in the resume phase
    want_stop = 1'b1;
    tick(5);
    pulse_irq(4'h6);
    exp_pend = 4'h6;
    want_stop = 1'b0;
    tick(7);
    check("exec in resume", 4'h0, {3'h0, exec});
    want_stop = 1'b1;
    acks = 0;
    repeat (6) begin
      tick(1);
      if (ack === 1'b1) acks++;
    end
    check("ack on re-entry", 4'h1, 4'(acks));
    check("pending on re-entry", exp_pend, pending);
    release_and_serve();
    $display("re-entry test done");
    i_trip_sensor = 1'b1;
    tick(5);
    check("trip set", 4'h0, {3'h0, shut_n});
    check("exec halted", 4'h0, {3'h0, exec});
    i_trip_sensor = 1'b0;
    tick(8);
    check("trip latched", 4'h0, {3'h0, shut_n});
    check("exec still halted", 4'h0, {3'h0, exec});
    reset_dut(1'b1);
    check("trip kept hot", 4'h0, {3'h0, shut_n});
    reset_dut(1'b0);
    check("trip cleared", 4'h1, {3'h0, shut_n});
    check("exec after clear", 4'h1, {3'h0, exec});
    $display("thermal test done");
    tally_and_finish();
  end
endmodule
